// ### rtl/dscm_monitor.sv
// Purpose: diagnostic serial command monitor, serial in, text reports out
// Assumes: status values arrive on ports from logic on the same clock
// Notes:   commands arriving while a report runs are dropped
`timescale 1ns/1ps
module dscm_monitor #(
  parameter int unsigned FIFO_W = 8,
  parameter int unsigned FIFO_D = dscm_pkg::FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        rxd,
  output logic             txd_r,
  input  wire logic        jumper_alt,
  input  wire logic [255:0] router_regs,
  input  wire logic [191:0] repeater_regs,
  input  wire logic [7:0]  temp_local,
  input  wire logic [7:0]  temp_ext,
  input  wire logic [3:0]  power_state,
  input  wire logic [15:0] t_pgood_ms,
  input  wire logic [15:0] t_prog_ms,
  input  wire logic [15:0] t_perst_ms,
  input  wire logic [15:0] t_reboot_ms,
  input  wire logic [79:0] fan_power,
  input  wire logic [159:0] fan_tach,
  input  wire logic [159:0] fan_rpm,
  input  wire logic [11:0] fan_speed,
  output logic             router_reset_r,
  output logic             early_reset_r,
  output logic             boot_backup_r
);
  import dscm_pkg::*;

  // ************
  // receiver
  // ************
  logic [2:0]  rx_s_r;
  logic        rx_f_r;
  logic        rx_busy_r;
  logic [7:0]  rx_cnt_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_valid_r;
  logic [7:0]  rx_byte_r;
  wire         rx_tick = (rx_cnt_r == 8'(BAUD_DIV - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_r     <= 3'h7;
      rx_f_r     <= 1'b1;
      rx_busy_r  <= 1'b0;
      rx_cnt_r   <= '0;
      rx_bit_r   <= '0;
      rx_sh_r    <= '0;
      rx_valid_r <= 1'b0;
      rx_byte_r  <= '0;
    end else begin
      rx_s_r     <= {rx_s_r[1:0], rxd};
      rx_f_r     <= (rx_s_r[1] == rx_s_r[2]) ? rx_s_r[1] : rx_f_r;
      rx_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        rx_cnt_r <= 8'(BAUD_DIV - 1 - HALF_DIV);
        rx_bit_r <= '0;
        rx_busy_r <= !rx_f_r;
      end else begin
        rx_cnt_r <= rx_tick ? '0 : rx_cnt_r + 8'h01;
        if (rx_tick) begin
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == 4'h0 && rx_f_r) begin
            rx_busy_r <= 1'b0;
          end else if (rx_bit_r == 4'(DATA_BITS + 1)) begin
            rx_busy_r  <= 1'b0;
            rx_valid_r <= rx_f_r;
            rx_byte_r  <= rx_sh_r;
          end else if (rx_bit_r != 4'h0) begin
            rx_sh_r <= {rx_f_r, rx_sh_r[7:1]};
          end
        end
      end
    end
  end

  // ************
  // command decode
  // ************
  // fold lower case onto upper case
  wire        is_lower = (rx_byte_r >= CH_LOW_A) && (rx_byte_r <= CH_LOW_Z);
  wire [7:0]  letter   = is_lower ? (rx_byte_r & ~CASE_BIT) : rx_byte_r;
  wire        known    = (letter == CMD_ROUTER) || (letter == CMD_RPT) || (letter == CMD_TEMP)
                      || (letter == CMD_POWER) || (letter == CMD_RESET) || (letter == CMD_EARLY)
                      || (letter == CMD_FAN) || (letter == CMD_VER);

  dscm_state_t state_r;
  dscm_state_t state_nxt;
  logic [7:0]  cmd_r;
  logic [7:0]  echo_ch_r;
  logic [4:0]  ech_r;
  logic [6:0]  k_r;
  logic [2:0]  dig_r;
  logic        hdr_r;
  logic        dig_fix_r;
  wire         accept = rx_valid_r && known && (state_r == ST_IDLE);

  // ************
  // report item table
  // ************
  function automatic logic [7:0] echo_char(input logic [4:0] i);
    logic [135:0] s;
    s = "input received - ";
    echo_char = s[8*(ECHO_LEN-1-i) +: 8];
  endfunction

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? CH_ZERO + 8'(n) : CH_HEXA + 8'(n);
  endfunction

  logic [3:0] hist_r [HIST_DEPTH];
  logic [3:0] pstate_r;
  logic [31:0] it_val;
  logic [2:0]  it_nd;
  logic        it_eol;
  logic        it_last;
  logic [6:0]  n_items;
  logic [6:0]  hk;
  logic [6:0]  fk;
  assign hk = k_r - 7'd5;
  assign fk = k_r - 7'(FAN_UNITS);

  always_comb begin
    it_val  = '0;
    it_nd   = 3'd0;
    it_eol  = 1'b0;
    it_last = 1'b0;
    n_items = '0;
    case (cmd_r)
      CMD_ROUTER: begin
        n_items = 7'(ROUTER_WORDS);
        it_val  = router_regs[32*k_r[2:0] +: 32];
        it_nd   = 3'd7;
        it_eol  = (k_r == 7'(ROUTER_WORDS - 1));
      end
      CMD_RPT: begin
        n_items = 7'(RPT_BYTES);
        it_val  = {24'h00_0000, repeater_regs[8*k_r[4:0] +: 8]};
        it_nd   = 3'd1;
        it_eol  = (k_r[2:0] == 3'(RPT_ROW - 1));
      end
      CMD_TEMP: begin
        n_items = 7'd2;
        it_val  = {24'h00_0000, (k_r == 7'd0) ? temp_local : temp_ext};
        it_nd   = 3'd1;
        it_eol  = (k_r == 7'd1);
      end
      CMD_POWER: begin
        n_items = 7'(HIST_DEPTH + 5);
        it_nd   = 3'd0;
        if (k_r == 7'd0) begin
          it_val = {28'h000_0000, pstate_r};
          it_eol = 1'b1;
        end else if (k_r < 7'd5) begin
          it_val = {16'h0000, (k_r == 7'd1) ? t_pgood_ms : (k_r == 7'd2) ? t_prog_ms
                              : (k_r == 7'd3) ? t_perst_ms : t_reboot_ms};
          it_nd  = 3'd3;
          it_eol = (k_r == 7'd4);
        end else begin
          it_val = {28'h000_0000, hist_r[hk[5:0]]};
          it_eol = ((hk % 7'(HIST_ROW)) == 7'(HIST_ROW - 1));
        end
      end
      // unit power, tach counts, rpm, region speeds
      CMD_FAN: begin
        n_items = 7'(FAN_UNITS + 2 * FAN_TACHS + 1);
        it_nd   = 3'd3;
        if (k_r < 7'(FAN_UNITS)) begin
          it_val = {16'h0000, fan_power[16*k_r[2:0] +: 16]};
          it_eol = (k_r == 7'(FAN_UNITS - 1));
        end else if (fk < 7'(FAN_TACHS)) begin
          it_val = {16'h0000, fan_tach[16*fk[3:0] +: 16]};
          it_eol = (fk == 7'(FAN_TACHS - 1));
        end else if (fk < 7'(2 * FAN_TACHS)) begin
          it_val = {16'h0000, fan_rpm[16*(fk[4:0] - 5'(FAN_TACHS)) +: 16]};
          it_eol = (fk == 7'(2 * FAN_TACHS - 1));
        end else begin
          it_val = {20'h0_0000, fan_speed};
          it_nd  = 3'd2;
          it_eol = 1'b1;
        end
      end
      CMD_VER: begin
        n_items = 7'd1;
        it_val  = VERSION_STAMP;
        it_nd   = 3'd7;
        it_eol  = 1'b1;
      end
      default: begin
        n_items = '0;
      end
    endcase
    it_last = (k_r == n_items - 7'd1);
  end

  // ************
  // report sequencer
  // ************
  logic        f_in_ready;
  logic [7:0]  out_ch;
  // no push in the cycle that loads the digit count
  wire         f_in_valid = (state_r != ST_IDLE) && !dig_fix_r;
  wire         step       = f_in_valid && f_in_ready;
  wire  [3:0]  nib        = it_val[4*dig_r +: 4];

  always_comb begin
    case (state_r)
      ST_ECHO: out_ch = (ech_r == 5'(ECHO_LEN)) ? echo_ch_r : echo_char(ech_r);
      ST_DIG:  out_ch = hex_ch(nib);
      ST_SP:   out_ch = CH_SPACE;
      ST_CR:   out_ch = CH_CR;
      ST_LF:   out_ch = CH_LF;
      default: out_ch = CH_SPACE;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_ECHO : ST_IDLE;
      ST_ECHO: state_nxt = (step && ech_r == 5'(ECHO_LEN)) ? ST_CR : ST_ECHO;
      ST_DIG:  state_nxt = (step && dig_r == 3'd0) ? (it_eol ? ST_CR : ST_SP) : ST_DIG;
      ST_SP:   state_nxt = step ? ST_DIG : ST_SP;
      ST_CR:   state_nxt = step ? ST_LF : ST_CR;
      ST_LF: begin
        if (!step) begin
          state_nxt = ST_LF;
        end else if (hdr_r) begin
          state_nxt = (n_items == '0) ? ST_IDLE : ST_DIG;
        end else begin
          state_nxt = it_last ? ST_IDLE : ST_DIG;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      cmd_r     <= '0;
      echo_ch_r <= '0;
      ech_r     <= '0;
      k_r       <= '0;
      dig_r     <= '0;
      hdr_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // latch command and echo it first
      if (accept) begin
        cmd_r     <= letter;
        echo_ch_r <= rx_byte_r;
        ech_r     <= '0;
        k_r       <= '0;
        hdr_r     <= 1'b1;
      end
      if (state_r == ST_ECHO && step) begin
        ech_r <= ech_r + 5'd1;
      end
      if (state_r == ST_LF && step) begin
        hdr_r <= 1'b0;
        if (!hdr_r) begin
          k_r <= k_r + 7'd1;
        end
      end
      if (state_r == ST_SP && step) begin
        k_r <= k_r + 7'd1;
      end
      if (state_r == ST_DIG && step) begin
        dig_r <= dig_r - 3'd1;
      end else if (dig_fix_r) begin
        dig_r <= it_nd;
      end
    end
  end

  // first cycle in a digit run: item index has settled, digit count loads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dig_fix_r <= 1'b0;
    end else begin
      dig_fix_r <= (state_nxt == ST_DIG && state_r != ST_DIG);
    end
  end

  // ************
  // side effects and history
  // ************
  logic [2:0] jmp_r;
  logic       boot_done_r;

  // no reset: the jumper must already sit in these flops when reset lets go
  always_ff @(posedge clock) begin
    jmp_r <= {jmp_r[1:0], jumper_alt};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      router_reset_r <= 1'b0;
      early_reset_r  <= 1'b0;
      boot_backup_r  <= 1'b0;
      boot_done_r    <= 1'b0;
      pstate_r       <= '0;
    end else begin
      router_reset_r <= accept && (letter == CMD_RESET);
      if (accept && letter == CMD_EARLY) begin
        early_reset_r <= 1'b1;
      end
      // jumper caught once after reset release
      if (!boot_done_r && jmp_r[1] == jmp_r[2]) begin
        boot_done_r   <= 1'b1;
        boot_backup_r <= jmp_r[2];
      end
      pstate_r <= power_state;
    end
  end

  // shift in state on each change
  always_ff @(posedge clock) begin
    if (pstate_r != power_state) begin
      hist_r[0] <= pstate_r;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_r[i] <= hist_r[i-1];
      end
    end
  end

  // ************
  // buffer and transmitter
  // ************
  logic       f_out_valid;
  logic       f_out_ready;
  logic [7:0] f_out_data;

  dscm_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (out_ch),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  logic [8:0] tx_sh_r;
  logic [7:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic       tx_busy_r;
  wire        tx_tick = (tx_cnt_r == 8'(BAUD_DIV - 1));
  assign f_out_ready = !tx_busy_r;

  // start, 8 data lsb first, one stop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txd_r     <= 1'b1;
      tx_sh_r   <= '1;
      tx_cnt_r  <= '0;
      tx_bit_r  <= '0;
      tx_busy_r <= 1'b0;
    end else if (!tx_busy_r) begin
      if (f_out_valid) begin
        tx_busy_r <= 1'b1;
        txd_r     <= 1'b0;
        tx_sh_r   <= {1'b1, f_out_data};
        tx_cnt_r  <= '0;
        tx_bit_r  <= '0;
      end
    end else begin
      tx_cnt_r <= tx_tick ? '0 : tx_cnt_r + 8'h01;
      if (tx_tick) begin
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_bit_r == 4'(DATA_BITS + 1)) begin
          tx_busy_r <= 1'b0;
        end else begin
          txd_r   <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[8:1]};
        end
      end
    end
  end

  // ************
  // checks
  // ************
  a_case_fold: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_IDLE && rx_valid_r && rx_byte_r == (CMD_EARLY | CASE_BIT)
    |=> state_r == ST_ECHO && cmd_r == CMD_EARLY)
    else $error("lower case letter not taken as command");
  a_unknown_drop: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_IDLE && rx_valid_r && !known |=> state_r == ST_IDLE)
    else $error("unknown character started a report");
  a_echo_first: assert property (@(posedge clock) disable iff (!rst_n)
    accept |=> state_r == ST_ECHO && ech_r == 5'd0 && hdr_r)
    else $error("report did not open with echo");
  a_router_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    accept && letter == CMD_RESET |=> router_reset_r ##1 !router_reset_r)
    else $error("router reset not a single pulse");
  a_early_kept: assert property (@(posedge clock) disable iff (!rst_n)
    early_reset_r |=> early_reset_r)
    else $error("early reset setting lost");
  a_hist_shift: assert property (@(posedge clock) disable iff (!rst_n)
    pstate_r != power_state |=> hist_r[0] == $past(pstate_r))
    else $error("power history missed a state");
  a_boot_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    boot_done_r |=> $stable(boot_backup_r))
    else $error("boot image choice changed after power-on");
  a_tx_start: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_busy_r && f_out_valid |=> !txd_r [*5])
    else $error("start bit too short");
endmodule

// ### rtl/dscm_pkg.sv
// Purpose: constants for the diagnostic serial command monitor
// Assumes: 25 MHz clock, one clock domain
// Notes:   link, table and character figures live here; the fifo width FIFO_W and the digit count of each report item stay in the monitor
//
// What this block does
// - serial link 115.2k baud, 8 data bits, no parity, one stop bit.
// - command letters decode the same in upper or lower case.
// - router dump letter sends router switch registers as hex words.
// - repeater dump letter sends repeater registers as rows of hex bytes.
// - temperature letter reports incoming and outgoing air temperatures.
// - power letter reports current state and last 50 power states.
// - power report adds power-good, programming, reset-release and reboot times.
// - router reset letter resets router switch; terminal avoids it when running.
// - early reset letter records a setting with no chassis effect.
// - fan letter reports power, tachometer counts, rpm and region speeds.
// - version letter sends the fixed VERSION_STAMP, 00000000, as eight hex digits.
// - jumper in alternate position at power-on selects backup firmware.
package dscm_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned BAUD_RATE  = 115_200;
  localparam int unsigned BAUD_DIV   = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_DIV   = BAUD_DIV / 2;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned HIST_DEPTH = 50;
  localparam int unsigned HIST_ROW   = 10;
  localparam int unsigned ROUTER_WORDS = 8;
  localparam int unsigned RPT_BYTES  = 24;
  localparam int unsigned RPT_ROW    = 8;
  localparam int unsigned FAN_UNITS  = 5;
  localparam int unsigned FAN_TACHS  = 10;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned ECHO_LEN   = 17;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_HEXA  = 8'h57;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // command letters, upper case
  localparam logic [7:0] CMD_ROUTER = 8'h49;
  localparam logic [7:0] CMD_RPT    = 8'h4E;
  localparam logic [7:0] CMD_TEMP   = 8'h54;
  localparam logic [7:0] CMD_POWER  = 8'h50;
  localparam logic [7:0] CMD_RESET  = 8'h52;
  localparam logic [7:0] CMD_EARLY  = 8'h41;
  localparam logic [7:0] CMD_FAN    = 8'h46;
  localparam logic [7:0] CMD_VER    = 8'h44;
  localparam logic [31:0] VERSION_STAMP = 32'h0000_0000;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ECHO = 6'b00_0010,
    ST_DIG  = 6'b00_0100,
    ST_SP   = 6'b00_1000,
    ST_CR   = 6'b01_0000,
    ST_LF   = 6'b10_0000
  } dscm_state_t;
endpackage

// ### rtl/dscm_fifo.sv
// Purpose: byte fifo between report generator and serial transmitter
// Assumes: single clock, valid/ready on both sides
// Notes:   read data comes from a register
`timescale 1ns/1ps
module dscm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             rd_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire              load = (cnt_r != '0) && (!rd_r || pop);

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r     <= '0;
      rp_r     <= '0;
      cnt_r    <= '0;
      rd_r     <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (load) begin
        rp_r     <= rp_r + 1'b1;
        out_data <= mem[rp_r];
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      rd_r  <= load ? 1'b1 : (pop ? 1'b0 : rd_r);
    end
  end

  assign out_valid = rd_r;

  // ************
  // checks
  // ************
  a_fifo_hold: assert property (@(posedge clock) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
endmodule

// ### dv/dscm_term.sv
// Purpose: terminal model on the far side of the diagnostic serial port
// Assumes: 8N1 framing, bit time of BAUD_DIV clocks
// Notes:   received bytes queue up in rx_q for the bench to pop
`timescale 1ns/1ps
module dscm_term (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd
);
  import dscm_pkg::*;
  logic [7:0] rx_q[$];
  int         frame_err = 0;
  initial rxd = 1'b1;
  // ****************************************
  // sender
  // ****************************************
  // start, lsb first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (BAUD_DIV - 1) @(posedge clock);
    end
  endtask
  // ****************************************
  // receiver
  // ****************************************
  // mid-bit sampling of 8N1
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (HALF_DIV) @(posedge clock);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge clock);
        b[i] = txd;
      end
      repeat (BAUD_DIV) @(posedge clock);
      // a low stop bit is a broken frame, still kept for comparison
      if (txd !== 1'b1) frame_err++;
      rx_q.push_back(b);
    end
  end
endmodule

// ### dv/dscm_monitor_tb.sv
// Purpose: self-checking bench for the diagnostic serial command monitor
// Assumes: 25 MHz clock; reports are long, so only echo-only commands run
// Notes:   each character costs about 2171 clocks on the wire
`timescale 1ns/1ps
module dscm_monitor_tb;
  import dscm_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         rxd;
  logic         txd_r;
  logic         jumper_alt = 1'b0;
  logic [255:0] router_regs = {8{32'h1234_5678}};
  logic [191:0] repeater_regs = {24{8'h5a}};
  logic [7:0]   temp_local = 8'h18;
  logic [7:0]   temp_ext = 8'h1d;
  logic [3:0]   power_state = 4'h8;
  logic [15:0]  t_pgood_ms = 16'h0012;
  logic [15:0]  t_prog_ms = 16'h0039;
  logic [15:0]  t_perst_ms = 16'h007a;
  logic [15:0]  t_reboot_ms = 16'h0005;
  logic [79:0]  fan_power = {5{16'h0abc}};
  logic [159:0] fan_tach = {10{16'h0ee6}};
  logic [159:0] fan_rpm = {10{16'h1eb9}};
  logic [11:0]  fan_speed = 12'h323;
  logic         router_reset_r;
  logic         early_reset_r;
  logic         boot_backup_r;
  int           fail_count = 0;
  int           check_count = 0;
  logic [7:0]   pulse_cnt = 8'h00;
  initial begin
    forever #20 clock = ~clock;
  end
  dscm_monitor u_dscm_monitor (
    .clock(clock), .rst_n(rst_n), .rxd(rxd), .txd_r(txd_r), .jumper_alt(jumper_alt),
    .router_regs(router_regs), .repeater_regs(repeater_regs), .temp_local(temp_local),
    .temp_ext(temp_ext), .power_state(power_state), .t_pgood_ms(t_pgood_ms),
    .t_prog_ms(t_prog_ms), .t_perst_ms(t_perst_ms), .t_reboot_ms(t_reboot_ms),
    .fan_power(fan_power), .fan_tach(fan_tach), .fan_rpm(fan_rpm), .fan_speed(fan_speed),
    .router_reset_r(router_reset_r), .early_reset_r(early_reset_r), .boot_backup_r(boot_backup_r)
  );
  dscm_term u_dscm_term (.clock(clock), .txd(txd_r), .rxd(rxd));
  // counts every cycle the router reset is high
  always @(posedge clock) begin
    if (router_reset_r === 1'b1) pulse_cnt <= pulse_cnt + 8'h01;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expect_str(input string s);
    logic [7:0] got;
    int         n;
    for (int i = 0; i < s.len(); i++) begin
      n = 0;
      // one character takes about 2170 clocks on the wire
      while (u_dscm_term.rx_q.size() == 0 && n < 4000) begin
        @(posedge clock);
        n++;
      end
      if (n >= 4000) got = 8'h00;
      else got = u_dscm_term.rx_q.pop_front();
      check(got, s[i]);
    end
  endtask
  task automatic do_reset(input logic jmp);
    @(posedge clock);
    jumper_alt <= jmp;
    // jumper steady for 3 cycles before release
    repeat (1) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_reset_values;
    do_reset(1'b0);
    check({7'h00, boot_backup_r}, 8'h00);
    check({7'h00, early_reset_r}, 8'h00);
    check({7'h00, txd_r}, 8'h01);
  endtask
  task automatic sc_ignored_char;
    u_dscm_term.send(8'h78);
    // a false echo would land about 1970 clocks after the stop bit
    repeat (11 * BAUD_DIV) @(posedge clock);
    check(8'(u_dscm_term.rx_q.size()), 8'h00);
    check(pulse_cnt, 8'h00);
  endtask
  task automatic sc_router_reset;
    // power state moves while idle, feeding the history
    power_state <= 4'h9;
    u_dscm_term.send(8'h52);
    expect_str("input received - R\r\n");
    check(pulse_cnt, 8'h01);
    check({7'h00, early_reset_r}, 8'h00);
  endtask
  task automatic sc_early_lower;
    u_dscm_term.send(8'h61);
    expect_str("input received - a\r\n");
    check({7'h00, early_reset_r}, 8'h01);
    check(pulse_cnt, 8'h01);
    check(8'(u_dscm_term.frame_err), 8'h00);
  endtask
  task automatic sc_backup_boot;
    do_reset(1'b1);
    check({7'h00, boot_backup_r}, 8'h01);
    check({7'h00, early_reset_r}, 8'h00);
    jumper_alt <= 1'b0;
    repeat (8) @(posedge clock);
    // fixed after power-on, jumper moves are ignored
    check({7'h00, boot_backup_r}, 8'h01);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    sc_reset_values();
    sc_ignored_char();
    sc_router_reset();
    sc_early_lower();
    sc_backup_boot();
    print_verdict();
  end
  initial begin
    // main sequence needs roughly 95.5k clocks
    repeat (99000) @(posedge clock);
    fail_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    print_verdict();
  end
endmodule
